/* File: aagc_control.sv */
module aagc_control
	import aagc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = MS_NS / CLK_PERIOD_NS
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic [7:0]  feedback_int,
	input  wire logic [5:0]  input_div_code,
	input  wire logic [2:0]  output_div_code,
	output logic      [12:0] feedback_ratio_x32,
	output logic      [9:0]  pll_div_product,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample,
	input  wire logic [3:0]  manual_gain,
	input  wire logic [2:0]  gain_fall_step_time,
	output aagc_cfg_t        cfg_out,
	output logic      [3:0]  preamp_gain,
	output logic             gate_mute
);
	logic [7:0]  reg_frac;
	logic [7:0]  reg_src;
	logic [7:0]  reg_cmp;
	logic [7:0]  reg_tgt;
	logic [7:0]  reg_lim;
	logic [7:0]  n_eff;
	logic [15:0] mag;
	logic [6:0]  tgt_db;
	logic [6:0]  up_db;
	logic [6:0]  thr_db;
	logic [15:0] tgt_lin;
	logic [15:0] up_lin;
	logic [15:0] thr_lin;
	logic [14:0] frame_len;
	logic [14:0] samp_cnt;
	logic [15:0] peak;
	logic [15:0] frame_peak;
	logic        frame_done;
	logic [2:0]  quiet_frames;
	aagc_dir_t   dir;
	aagc_dir_t   dir_prev;
	logic [17:0] tick_cnt;
	logic [12:0] step_ms;
	logic [12:0] step_limit;
	logic        step_due;
	logic        prev_neg;
	logic        zc;
	logic        apply;
	logic [3:0]  agc_gain;
	logic [3:0]  ceil;
	logic        auto_en;

	// Register writes; unmapped offsets are ignored
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_frac <= RST_FRAC;
			reg_src <= RST_SRC;
			reg_cmp <= RST_CMP;
			reg_tgt <= RST_TGT;
			reg_lim <= RST_LIM;
		end else if (reg_wr_en) begin
			case (reg_addr)
				OFS_FRAC: reg_frac <= reg_wdata & FRAC_MASK;
				OFS_SRC: reg_src <= reg_wdata;
				OFS_CMP: reg_cmp <= reg_wdata;
				OFS_TGT: reg_tgt <= reg_wdata;
				OFS_LIM: reg_lim <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read port; status shows live gain, direction and gate
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd_en) begin
			case (reg_addr)
				OFS_FRAC: reg_rdata <= reg_frac;
				OFS_SRC: reg_rdata <= reg_src;
				OFS_CMP: reg_rdata <= reg_cmp;
				OFS_TGT: reg_rdata <= reg_tgt;
				OFS_LIM: reg_rdata <= reg_lim;
				OFS_STAT: reg_rdata <= {1'b0, gate_mute, dir, agc_gain};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Integer part saturates the way the divider does outside 10..250
	always_comb begin
		if (feedback_int < N_MIN) begin
			n_eff = N_MIN;
		end else if (feedback_int > N_MAX) begin
			n_eff = N_MAX;
		end else begin
			n_eff = feedback_int;
		end
	end

	// Ratio in 1/32 units; only fraction bits 4:0 enter the concatenation, bits 6:5 are dropped
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			feedback_ratio_x32 <= 13'h0000;
			pll_div_product <= 10'h000;
		end else begin
			feedback_ratio_x32 <= {n_eff, reg_frac[MOD_LSB+:5]};
			pll_div_product <= 10'(({4'h0, input_div_code} + 10'h001)
				* ({7'h00, output_div_code} + 10'h001));
		end
	end

	// Configuration decode toward the converter and serial interface
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_out <= '0;
		end else begin
			cfg_out.src_mic <= reg_src[SRC_MIC];
			cfg_out.src_phone <= reg_src[SRC_PHONE];
			cfg_out.src_left <= reg_src[SRC_LEFT];
			cfg_out.src_right <= reg_src[SRC_RIGHT];
			cfg_out.rate_hint <= reg_src[RATE_LSB+:2];
			unique case (reg_src[HPF_LSB+:2])
				2'b01: cfg_out.hpf <= HPF_HIGH;
				2'b10: cfg_out.hpf <= HPF_LOW;
				2'b00, 2'b11: cfg_out.hpf <= HPF_OFF;
			endcase
			cfg_out.law_select <= reg_cmp[LAW_BIT];
			cfg_out.compress_enable <= reg_cmp[CMP_BIT];
			cfg_out.adc_mute <= reg_cmp[MUTE_BIT];
			cfg_out.dac_clock_master <= reg_cmp[DACM_BIT];
			cfg_out.short_word_master <= reg_cmp[SHORT_BIT];
			cfg_out.auto_gain_enable <= reg_tgt[EN_BIT];
		end
	end

	// Levels; comparisons are on sample magnitude against full scale
	assign auto_en = reg_tgt[EN_BIT];
	assign ceil = reg_lim[CEIL_LSB+:4];
	assign mag = sample[15] ? 16'(-sample) : sample;
	assign tgt_db = TGT_BASE_DB + TGT_STEP_DB * {4'h0, reg_tgt[TGT_LSB+:3]};
	assign up_db = reg_lim[TIGHT_BIT] ? tgt_db - TIGHT_DB : tgt_db >> 1;
	assign thr_db = THR_BASE_DB - THR_STEP_DB * {4'h0, reg_tgt[THR_LSB+:3]};
	assign tgt_lin = aagc_db_to_lin(tgt_db);
	assign up_lin = aagc_db_to_lin(up_db);
	assign thr_lin = aagc_db_to_lin(thr_db);

	// Frame length in samples from the rate hint, not the real rate
	always_comb begin
		frame_len = 15'h0000;
		unique case (reg_src[RATE_LSB+:2])
			2'b00: frame_len = 15'(aagc_frame_ms(reg_cmp[FRAME_LSB+:3]) * 15'h0008);
			2'b01: frame_len = 15'(aagc_frame_ms(reg_cmp[FRAME_LSB+:3]) * 15'h000C);
			2'b10: frame_len = 15'(aagc_frame_ms(reg_cmp[FRAME_LSB+:3]) * 15'h0010);
			2'b11: frame_len = 15'(aagc_frame_ms(reg_cmp[FRAME_LSB+:3]) * 15'h0018);
		endcase
	end

	// Peak detector per frame
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			samp_cnt <= 15'h0000;
			peak <= 16'h0000;
			frame_peak <= 16'h0000;
			frame_done <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (sample_valid) begin
				if (samp_cnt + 15'h0001 >= frame_len) begin
					samp_cnt <= 15'h0000;
					frame_peak <= (mag > peak) ? mag : peak;
					peak <= 16'h0000;
					frame_done <= 1'b1;
				end else begin
					samp_cnt <= samp_cnt + 15'h0001;
					if (mag > peak) begin
						peak <= mag;
					end
				end
			end
		end
	end

	// Direction decision; a loud sample overrides the frame verdict at once
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dir <= DIR_HOLD;
			quiet_frames <= 3'h0;
		end else begin
			if (frame_done) begin
				if (frame_peak > up_lin) begin
					dir <= DIR_DOWN;
					quiet_frames <= 3'h0;
				end else if (frame_peak < thr_lin) begin
					dir <= DIR_HOLD;
					if (quiet_frames < GATE_FRAMES) begin
						quiet_frames <= quiet_frames + 3'h1;
					end
				end else if (frame_peak < tgt_lin) begin
					dir <= DIR_UP;
					quiet_frames <= 3'h0;
				end else begin
					dir <= DIR_HOLD;
					quiet_frames <= 3'h0;
				end
			end
			if (sample_valid && mag > up_lin) begin
				dir <= DIR_DOWN;
			end
		end
	end

	// Gate only after several sub-threshold frames, so speech gaps pass
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gate_mute <= 1'b0;
		end else begin
			gate_mute <= reg_tgt[GATE_BIT] && quiet_frames >= GATE_FRAMES;
		end
	end

	// Zero crossing: sign flip or exact zero between valid samples
	assign zc = sample_valid && (sample[15] != prev_neg || sample == 16'h0000);
	assign apply = step_due && zc && dir != DIR_HOLD;
	assign step_limit = STEP_BASE_MS << ((dir == DIR_DOWN) ? gain_fall_step_time
		: reg_lim[RISE_LSB+:3]);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prev_neg <= 1'b0;
		end else if (sample_valid) begin
			prev_neg <= sample[15];
		end
	end

	// Millisecond tick and step timer; a set wins over the clear by apply
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= 18'h0_0000;
			step_ms <= 13'h0000;
			step_due <= 1'b0;
			dir_prev <= DIR_HOLD;
		end else begin
			dir_prev <= dir;
			if (tick_cnt >= 18'(TICK_CYCLES - 1)) begin
				tick_cnt <= 18'h0_0000;
			end else begin
				tick_cnt <= tick_cnt + 18'h0_0001;
			end
			if (apply) begin
				step_due <= 1'b0;
			end
			if (dir == DIR_HOLD) begin
				step_ms <= 13'h0000;
				step_due <= 1'b0;
			end else if (dir == DIR_DOWN && dir_prev != DIR_DOWN) begin
				step_ms <= 13'h0000;
				step_due <= 1'b1;
			end else if (tick_cnt >= 18'(TICK_CYCLES - 1)) begin
				if (step_ms + 13'h0001 >= step_limit) begin
					step_ms <= 13'h0000;
					step_due <= 1'b1;
				end else begin
					step_ms <= step_ms + 13'h0001;
				end
			end
		end
	end

	// Gain tracks the manual setting while automatic control is off
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			agc_gain <= 4'h0;
		end else if (!auto_en) begin
			agc_gain <= manual_gain;
		end else if (agc_gain > ceil) begin
			agc_gain <= ceil;
		end else if (apply) begin
			if (dir == DIR_DOWN && agc_gain != 4'h0) begin
				agc_gain <= agc_gain - 4'h1;
			end else if (dir == DIR_UP && agc_gain < ceil) begin
				agc_gain <= agc_gain + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			preamp_gain <= 4'h0;
		end else begin
			preamp_gain <= agc_gain;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_step_cause;
		$past(auto_en) && $past(agc_gain) <= $past(ceil) && $past(zc) && $past(step_due);
	endsequence

	a_ratio_form: assert property (!$past(rst) |->
		feedback_ratio_x32[4:0] == $past(reg_frac[4:0]) && feedback_ratio_x32[12:5] >= N_MIN)
		else $error("feedback ratio wrong");
	a_div_product: assert property (!$past(rst) |->
		##1 pll_div_product == 10'(($past(input_div_code) + 7'h01) * ($past(output_div_code) + 4'h1)))
		else $error("divider product wrong");
	a_source_map: assert property (
		##1 cfg_out.src_phone == $past(reg_src[SRC_PHONE]) && cfg_out.src_right == $past(reg_src[SRC_RIGHT]))
		else $error("source select wrong");
	a_hpf_select: assert property (
		reg_src[HPF_LSB+:2] == 2'b11 |=> cfg_out.hpf == HPF_OFF)
		else $error("filter select wrong");
	a_law_mute: assert property (
		##1 cfg_out.adc_mute == $past(reg_cmp[MUTE_BIT]) && cfg_out.law_select == $past(reg_cmp[LAW_BIT]))
		else $error("mute or law wrong");
	a_attack_now: assert property (
		sample_valid && mag > up_lin |=> dir == DIR_DOWN)
		else $error("attack not immediate");
	a_gain_step: assert property (
		$changed(agc_gain) && $past(auto_en) && $past(agc_gain) <= $past(ceil) |-> s_step_cause)
		else $error("gain moved off zero crossing");
	a_gain_unit: assert property (
		$changed(agc_gain) && $past(auto_en) && $past(agc_gain) <= $past(ceil)
		|-> agc_gain == $past(agc_gain) + 4'h1 || agc_gain + 4'h1 == $past(agc_gain))
		else $error("gain step not one code");
	a_gain_cap: assert property (
		$past(auto_en) && $stable(reg_lim) |-> agc_gain <= ceil)
		else $error("gain above ceiling");
	a_gate_hold: assert property (
		gate_mute |-> $past(quiet_frames) >= GATE_FRAMES && $past(reg_tgt[GATE_BIT]))
		else $error("gate without quiet period");
endmodule : aagc_control

/* File: aagc_pkg.sv */
// Operation
// - Feedback ratio is integer setting plus fraction setting over 32; the code takes fraction bits 4:0 only.
// - Output frequency is input times ratio over input and output divider product.
// - Bits 0 to 3 add mic, phone, left and right bus to converter.
// - Bits 7:6 pick high-pass: 00 and 11 off, 01 higher, 10 lower cut-off.
// - Law bit 0 means mu-law, 1 means A-law, both directions.
// - Compress bit compresses 16-bit samples and marks incoming data compressed.
// - Mute bit 2 silences every analog input to the converter.
// - Frame field 5:3 sets 96 to 1000 ms frame length.
// - Each frame the peak is captured and compared against the target.
// - Bit 6 lets the playback clock system master the serial interface.
// - Bit 7 selects 16-bit master words, last two bit periods 25% short.
// - Enable bit 0 lets the block drive preamp gain; host routes mic.
// - Target field 3:1 selects -6 dB down to -20 dB in 2 dB steps.
// - Gate bit 4 mutes sub-threshold signal after a quiet period.
// - Threshold field 7:5 spans -72 to -30 dB; below it gain holds.
// - Ceiling field 3:0 caps gain from 6 dB to 36 dB.
// - Loose window reaches half the target in dB; tight reaches target plus 3 dB.
// - Above the window the gain starts falling at once at fall rate.
// - Gain changes are applied only at a zero crossing; the code clamps gain down to a lowered ceiling at once.
package aagc_pkg;
	localparam logic [7:0] OFS_FRAC = 8'h05, OFS_SRC = 8'h06, OFS_CMP = 8'h07;
	localparam logic [7:0] OFS_TGT = 8'h08, OFS_LIM = 8'h09, OFS_STAT = 8'h7F;
	localparam logic [7:0] RST_FRAC = 8'h00, RST_SRC = 8'h00, RST_CMP = 8'h00;
	localparam logic [7:0] RST_TGT = 8'h00, RST_LIM = 8'h00, FRAC_MASK = 8'h7F;
	localparam int MOD_LSB = 0, SRC_MIC = 0, SRC_PHONE = 1, SRC_LEFT = 2, SRC_RIGHT = 3;
	localparam int RATE_LSB = 4, HPF_LSB = 6, LAW_BIT = 0, CMP_BIT = 1, MUTE_BIT = 2;
	localparam int FRAME_LSB = 3, DACM_BIT = 6, SHORT_BIT = 7, EN_BIT = 0, TGT_LSB = 1;
	localparam int GATE_BIT = 4, THR_LSB = 5, CEIL_LSB = 0, RISE_LSB = 4, TIGHT_BIT = 7;
	localparam logic [7:0] N_MIN = 8'h0A, N_MAX = 8'hFA;
	localparam logic [6:0] TGT_BASE_DB = 7'h06, TGT_STEP_DB = 7'h02, TIGHT_DB = 7'h03;
	localparam logic [6:0] THR_BASE_DB = 7'h48, THR_STEP_DB = 7'h06;
	localparam logic [15:0] FULL_SCALE = 16'h7FFF;
	localparam logic [12:0] STEP_BASE_MS = 13'h0020;
	localparam logic [2:0] GATE_FRAMES = 3'h4;
	localparam int unsigned CLK_PERIOD_NS = 5, MS_NS = 1000000;
	typedef enum logic [1:0] {HPF_OFF, HPF_HIGH, HPF_LOW} aagc_hpf_t;
	typedef enum logic [1:0] {DIR_HOLD, DIR_UP, DIR_DOWN} aagc_dir_t;
	typedef struct packed {
		logic src_mic, src_phone, src_left, src_right;
		logic [1:0] rate_hint;
		aagc_hpf_t hpf;
		logic law_select, compress_enable, adc_mute;
		logic dac_clock_master, short_word_master, auto_gain_enable;
	} aagc_cfg_t;
	// Attenuation in dB to linear magnitude: 6 dB per octave plus fine table
	function automatic logic [15:0] aagc_db_to_lin(input logic [6:0] db);
		logic [6:0] q;
		logic [7:0] f;
		logic [23:0] p;
		q = db / 7'h06;
		unique case (db % 7'h06)
			7'h00: f = 8'hFF;
			7'h01: f = 8'hE4;
			7'h02: f = 8'hCB;
			7'h03: f = 8'hB5;
			7'h04: f = 8'hA2;
			7'h05: f = 8'h90;
			default: f = 8'h00;
		endcase
		p = 24'(FULL_SCALE) * 24'(f);
		return 16'(p >> (7'h08 + q));
	endfunction : aagc_db_to_lin
	// Frame length in ms per code
	function automatic logic [9:0] aagc_frame_ms(input logic [2:0] c);
		unique case (c)
			3'h0: return 10'h060;
			3'h1: return 10'h080;
			3'h2: return 10'h0C0;
			3'h3: return 10'h100;
			3'h4: return 10'h180;
			3'h5: return 10'h200;
			3'h6: return 10'h300;
			3'h7: return 10'h3E8;
		endcase
	endfunction : aagc_frame_ms
endpackage : aagc_pkg

/* File: aagc_preamp_model.sv */
module aagc_preamp_model (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic [15:0] level,
	output logic             sample_valid,
	output logic      [15:0] sample
);
	timeunit 1ns;
	timeprecision 1ps;
	logic neg;
	// Converter output: alternating sign, so every sample after the first one after reset is a zero crossing
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			neg <= 1'b0;
			sample_valid <= 1'b0;
			sample <= 16'h0000;
		end else if (run) begin
			neg <= ~neg;
			sample_valid <= 1'b1;
			sample <= neg ? -level : level;
		end else begin
			// Idle bus shows garbage, not a stale sample
			sample_valid <= 1'b0;
			sample <= ~sample;
		end
	end
endmodule : aagc_preamp_model

/* File: aagc_control_bench.sv */
module aagc_control_bench
	import aagc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 30000;
	logic        ref_clk, rst, reg_wr_en, reg_rd_en, run, sample_valid, gate_mute;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, feedback_int, rd;
	logic [5:0]  input_div_code;
	logic [2:0]  output_div_code, gain_fall_step_time;
	logic [12:0] feedback_ratio_x32;
	logic [9:0]  pll_div_product;
	logic [15:0] sample, level;
	logic [3:0]  manual_gain, preamp_gain;
	aagc_cfg_t   cfg_out;
	aagc_hpf_t   hpf_exp [4] = '{HPF_OFF, HPF_HIGH, HPF_LOW, HPF_OFF};
	int          fails, tests_run, cycles;

	aagc_control #(.TICK_CYCLES(4)) dut_u (.ref_clk(ref_clk), .rst(rst),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .feedback_int(feedback_int),
		.input_div_code(input_div_code), .output_div_code(output_div_code),
		.feedback_ratio_x32(feedback_ratio_x32), .pll_div_product(pll_div_product),
		.sample_valid(sample_valid), .sample(sample), .manual_gain(manual_gain),
		.gain_fall_step_time(gain_fall_step_time), .cfg_out(cfg_out),
		.preamp_gain(preamp_gain), .gate_mute(gate_mute));

	aagc_preamp_model model_u (.ref_clk(ref_clk), .rst(rst), .run(run), .level(level),
		.sample_valid(sample_valid), .sample(sample));

	// Free-running 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Hang guard, far above the longest planned sequence
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	// One-cycle strobes, launched just after an edge by the clock itself
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
	endtask : wr

	task automatic rdreg(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd_en <= 1'b0;
		cyc(1);
		rd = reg_rdata;
	endtask : rdreg

	task automatic done_test(input string name);
		$display("test %s finished at %0t ns", name, $time);
	endtask : done_test

	initial begin
		{reg_wr_en, reg_rd_en, run, rst} = 4'h1;
		{reg_addr, reg_wdata, level} = 32'h0000_0000;
		feedback_int = 8'h13;
		input_div_code = 6'h03;
		output_div_code = 3'h04;
		manual_gain = 4'h9;
		gain_fall_step_time = 3'h0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		// The five registers at offsets 5 to 9 clear to zero
		for (int a = 5; a <= 9; a++) begin
			rdreg(8'(a));
			check(16'(rd), 16'h0000);
		end
		done_test("reset");
		// N=19, M=4, P=5: VCO at 60 MHz from a sample-locked 12.288 MHz input
		wr(OFS_FRAC, 8'h11);
		cyc(2);
		check(16'(feedback_ratio_x32), 16'h0271);
		check(16'(pll_div_product), 16'h0014);
		feedback_int <= 8'h05;
		wr(OFS_FRAC, 8'hFF);
		cyc(2);
		check(16'(feedback_ratio_x32), 16'h015F);
		rdreg(OFS_FRAC);
		check(16'(rd), 16'h007F);
		done_test("pll");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_SRC, {2'(i), 2'(i), 4'(1 << i)});
			cyc(2);
			check(16'(cfg_out.hpf), 16'(hpf_exp[i]));
			check(16'(cfg_out.rate_hint), 16'(i));
			check({12'h000, cfg_out.src_right, cfg_out.src_left, cfg_out.src_phone,
				cfg_out.src_mic}, 16'(1 << i));
		end
		wr(OFS_CMP, 8'hC7);
		cyc(2);
		check(16'({cfg_out.law_select, cfg_out.compress_enable, cfg_out.adc_mute,
			cfg_out.dac_clock_master, cfg_out.short_word_master}), 16'h001F);
		wr(OFS_CMP, 8'h42);
		cyc(2);
		check(16'({cfg_out.law_select, cfg_out.compress_enable, cfg_out.adc_mute,
			cfg_out.dac_clock_master, cfg_out.short_word_master}), 16'h000A);
		done_test("config");
		wr(8'h10, 8'hA5);
		rdreg(8'h10);
		check(16'(rd), 16'h0000);
		wr(OFS_STAT, 8'hFF);
		rdreg(OFS_STAT);
		check(16'({rd[7:6], rd[3:0]}), 16'h0009);
		check(16'(preamp_gain), 16'h0009);
		done_test("access");
		// Loud input: gain must start falling straight away, floor at code 0
		wr(OFS_SRC, 8'h41);
		wr(OFS_LIM, 8'h0F);
		level <= 16'h7530;
		run <= 1'b1;
		wr(OFS_TGT, 8'h01);
		cyc(12);
		check(16'(preamp_gain), 16'h0008);
		check(16'(cfg_out.auto_gain_enable), 16'h0001);
		cyc(1500);
		check(16'(preamp_gain), 16'h0000);
		// Quiet input rises until the lowered ceiling
		wr(OFS_LIM, 8'h03);
		level <= 16'h03E8;
		cyc(3000);
		check(16'(preamp_gain), 16'h0003);
		done_test("fall_rise");
		// Target -12 dB: level sits in the loose window, above the tight one
		wr(OFS_TGT, 8'h07);
		level <= 16'h32C8;
		cyc(2000);
		check(16'(preamp_gain), 16'h0003);
		rdreg(OFS_STAT);
		check(16'(rd[5:4]), 16'h0000);
		wr(OFS_LIM, 8'h83);
		cyc(1000);
		check(16'(preamp_gain), 16'h0000);
		done_test("window");
		// Near-silence with the gate on; gain must hold meanwhile
		wr(OFS_TGT, 8'h17);
		level <= 16'h0003;
		cyc(1000);
		check(16'(gate_mute), 16'h0000);
		cyc(3000);
		check(16'(gate_mute), 16'h0001);
		check(16'(preamp_gain), 16'h0000);
		level <= 16'h2710;
		cyc(1700);
		check(16'(gate_mute), 16'h0000);
		done_test("gate");
		stop_test();
	end
endmodule : aagc_control_bench
